//--- verilog/mseq_pkg.sv
// Constants and types shared by the micro-sequencer files
package mseq_pkg;
  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int unsigned UA_W = 15;
  localparam int unsigned SP_W = 4;
  localparam int unsigned DEPTH = 16;
  localparam int unsigned MW_W = 24;
  localparam int unsigned AXI_AW = 8;
  // ---------------------------------------------------------------
  // Register byte offsets and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_NADR = 8'h08;
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned CTRL_STEP = 1;
  localparam int unsigned STAT_SP = 16;
  localparam int unsigned STAT_FLG = 20;
  localparam int unsigned STAT_PAGE = 22;
  localparam int unsigned STAT_MAINT = 23;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------
  // Microword layout
  // ---------------------------------------------------------------
  localparam int unsigned WF_FMT = 19;   // 3-bit format code
  localparam int unsigned WF_SEL = 18;   // OR selector bits
  localparam int unsigned WF_JHI = 12;   // 6-bit high jump field
  localparam int unsigned WF_JMID = 9;   // 3-bit middle jump field
  localparam int unsigned WF_JLO = 4;    // 5-bit low jump field
  localparam int unsigned WF_CTL = 0;    // sequence / branch control
  localparam int unsigned WF_MISC = 5;   // 7-bit flag function
  localparam logic [2:0] FMT_JUMP = 3'h1;
  localparam logic [2:0] FMT_DECODE = 3'h2;
  localparam logic [2:0] FMT_MISC = 3'h3;
  // Sequence control codes
  localparam logic [4:0] SC_SKIPNF = 5'h10;
  localparam logic [4:0] SC_LOOPA = 5'h11;
  localparam logic [4:0] SC_POP = 5'h12;
  localparam logic [4:0] SC_LOOPB = 5'h13;
  localparam logic [4:0] SC_RET = 5'h14;
  localparam logic [4:0] SC_NOP = 5'h15;
  localparam logic [4:0] SC_RET1 = 5'h16;
  localparam logic [4:0] SC_LOOPS = 5'h17;
  localparam logic [4:0] SC_FLAG0 = 5'h18;
  localparam logic [4:0] SC_FLAG1 = 5'h19;
  localparam logic [4:0] SC_SKIP = 5'h1e;
  // Branch control codes
  localparam logic [3:0] BC_JUMP = 4'h4;
  localparam logic [3:0] BC_CALL = 4'hc;
  localparam logic [3:0] BC_CALLC = 4'hd;
  localparam logic [3:0] BC_SKIPC = 4'he;
  // Reset values
  localparam logic [UA_W-1:0] UPC_RST = 15'h0000;
  localparam logic [SP_W-1:0] SP_RST = 4'h0;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {FN_NOP, FN_SKIP, FN_JUMP, FN_JSR, FN_RET,
    FN_RET1, FN_LOOP, FN_POP, FN_POPSKIP} mseq_fn_t;
  typedef enum logic [1:0] {PH_IDLE, PH_T225, PH_T270} mseq_ph_t;
endpackage

//--- verilog/mseq_stk_if.sv
// Port bundle between the sequencer and its return stack
`timescale 1ns/1ps
`default_nettype none
interface mseq_stk_if;
  logic wr_en;
  logic [3:0] wr_addr;
  logic [14:0] wr_data;
  logic [3:0] rd_addr;
  logic [14:0] rd_data;
  modport ctl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface
`default_nettype wire

//--- verilog/mseq_stack.sv
// Sixteen-entry return-address memory
`timescale 1ns/1ps
`default_nettype none
module mseq_stack
(
  input wire logic clk,  // Sequencer clock
  mseq_stk_if.mem stk    // Write and read ports
);
  logic [14:0] mem_q [16];

  // Store on the write strobe; contents need no reset
  always_ff @(posedge clk)
  begin
    if (stk.wr_en)
    begin
      mem_q[stk.wr_addr] <= stk.wr_data;
    end
  end

  // Asynchronous read so the top entry is ready within the cycle
  assign stk.rd_data = mem_q[stk.rd_addr];
endmodule // mseq_stack
`default_nettype wire

//--- verilog/mseq_top.sv
// Next-microaddress sequencer with return stack and AXI4-Lite control
//
// Summary of operation
// - 15-bit counter loads next address plus one at T270; bus drive gated.
// - Maintenance: load select low, shift input into LSB, MSB shown.
// - Return stack holds sixteen 15-bit addresses from the bus.
// - Call saves bus value; return drives top entry onto bus.
// - 4-bit pointer counts only when enabled; down on call, up on return.
// - Pointer wraps through all sixteen values; push and pop are inverse.
// - Call writes at T225 to pointer minus one; pointer moves at T270.
// - Return reads at pointer, pops at T270; loop keeps pointer.
// - Two housekeeping flags set or cleared by auxiliary word, skip tests.
// - Both flags forced clear while class decode phase is asserted.
// - Sequence code 15 is a plain NOP: counter value passes unchanged.
// - Codes 00-0F, 18-1D, 1F skip when true; 1E always skips.
// - Skip sets carry-in with counter drive: current address plus two.
// - Codes 10, 11-14, 16, 17 decode to return, loop and pop forms.
// - Branch codes 4 and C unconditional; others conditional; E skips.
// - Taken jump uses jump field, optionally ORed or from dispatch ROM.
// - High enable every jump; low enable jump format; ROM decode format.
// - Call jumps, pushes counter value and enables the pointer.
// - Return drives unmodified top entry and pops the stack.
// - Return plus one is a return with carry-in asserted.
// - Loop uses top entry like return but leaves pointer alone.
// - Pop acts as NOP, or skip once, and discards top entry.
// - Carry-in increment touches only low 11 bits; T270 plus-one load can cross a 2K page.
// - Page flag from auxiliary word supplies bit 14 of jumps.
// - Low jump bits ORed with selector only when select bit 18 set.
`timescale 1ns/1ps
`default_nettype none
module mseq_top
(
  input wire logic CLOCK,                  // 125 MHz clock
  input wire logic RESET_N,                // Async reset, active low
  input wire logic [7:0] S_AXI_AWADDR,     // Write address
  input wire logic S_AXI_AWVALID,          // Write address valid
  output logic S_AXI_AWREADY,              // Write address ready
  input wire logic [31:0] S_AXI_WDATA,     // Write data
  input wire logic [3:0] S_AXI_WSTRB,      // Write byte strobes
  input wire logic S_AXI_WVALID,           // Write data valid
  output logic S_AXI_WREADY,               // Write data ready
  output logic [1:0] S_AXI_BRESP,          // Write response
  output logic S_AXI_BVALID,               // Write response valid
  input wire logic S_AXI_BREADY,           // Write response ready
  input wire logic [7:0] S_AXI_ARADDR,     // Read address
  input wire logic S_AXI_ARVALID,          // Read address valid
  output logic S_AXI_ARREADY,              // Read address ready
  output logic [31:0] S_AXI_RDATA,         // Read data
  output logic [1:0] S_AXI_RRESP,          // Read response
  output logic S_AXI_RVALID,               // Read data valid
  input wire logic S_AXI_RREADY,           // Read data ready
  input wire logic [23:0] CURRENT_MICROWORD_REGISTER, // Current word
  input wire logic [31:0] SKIP_COND,       // Skip conditions by code
  input wire logic [15:0] JUMP_COND,       // Jump conditions by code
  input wire logic SYNC_CASE,              // Pop-and-skip case of 17
  input wire logic [4:0] SELECTOR_BITS,    // OR source for jumps
  input wire logic [7:0] DISPATCH_DATA,    // Dispatch ROM output
  input wire logic CLASS_DECODE_PHASE,     // Clears both flags
  input wire logic PARALLEL_LOAD_SELECT,   // Low selects shifting
  input wire logic COUNTER_CLOCK,          // Console shift step
  input wire logic CONSOLE_SHIFT_INPUT,    // Serial data into LSB
  output logic [14:0] NEXT_ADDRESS_LINES,  // Next microaddress
  output logic COUNTER_MSB,                // Counter MSB for examine
  output logic [1:0] STATE_FLAGS,          // Housekeeping flags
  output logic USER_PAGE_FLAG,             // Jump address bit 14
  output logic MICROCYCLE_END              // Pulse after T270 load
);
  // -----------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------
  mseq_stk_if stk ();
  mseq_pkg::mseq_fn_t fn;
  mseq_pkg::mseq_ph_t ph_q;
  logic [14:0] upc_q, nad_q, nad_d, bus, jump_addr;
  logic [3:0] sp_q;
  logic [1:0] flags_q;
  logic page_q, run_q, step_q, end_q;
  logic drive, rts, sp_en, cin, push, jmp, lo_en, rom_en;
  logic met;
  logic [2:0] fmt;
  logic [4:0] sequence_control_field;
  logic [3:0] bctl;
  logic [6:0] misc;
  logic [2:0] pl_s, ck_s, sh_s;
  logic maint, shift_ev, go;
  logic [7:0] aw_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic wr_fire, awr_q, wr_q, bv_q, arr_q, rv_q;
  logic [1:0] br_q, rr_q;
  logic [31:0] rd_q;

  assign fmt = CURRENT_MICROWORD_REGISTER[mseq_pkg::WF_FMT +: 3];
  assign sequence_control_field = CURRENT_MICROWORD_REGISTER[mseq_pkg::WF_CTL +: 5];
  assign bctl = CURRENT_MICROWORD_REGISTER[mseq_pkg::WF_CTL +: 4];
  assign misc = CURRENT_MICROWORD_REGISTER[mseq_pkg::WF_MISC +: 7];

  // -----------------------------------------------------------------
  // Console pins: two stages before use, third stage for edges
  // -----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      pl_s <= 3'h7;
      ck_s <= 3'h0;
      sh_s <= 3'h0;
    end
    else
    begin
      pl_s <= {pl_s[1:0], PARALLEL_LOAD_SELECT};
      ck_s <= {ck_s[1:0], COUNTER_CLOCK};
      sh_s <= {sh_s[1:0], CONSOLE_SHIFT_INPUT};
    end
  end

  // Shifting only while load select is low; microcycles stop meanwhile
  assign maint = !pl_s[1];
  assign shift_ev = maint && ck_s[1] && !ck_s[2];

  // -----------------------------------------------------------------
  // Function decode
  // -----------------------------------------------------------------
  // Condition pick; the two flags replace codes 18 and 19
  always_comb
  begin
    if (sequence_control_field == mseq_pkg::SC_FLAG0)
      met = flags_q[0];
    else if (sequence_control_field == mseq_pkg::SC_FLAG1)
      met = flags_q[1];
    else
      met = SKIP_COND[sequence_control_field];
  end

  always_comb
  begin
    fn = mseq_pkg::FN_NOP;
    if (fmt == mseq_pkg::FMT_JUMP || fmt == mseq_pkg::FMT_DECODE)
    begin
      case (bctl)
        mseq_pkg::BC_JUMP: fn = mseq_pkg::FN_JUMP;
        mseq_pkg::BC_CALL: fn = mseq_pkg::FN_JSR;
        mseq_pkg::BC_CALLC:
          fn = JUMP_COND[bctl] ? mseq_pkg::FN_JSR : mseq_pkg::FN_NOP;
        mseq_pkg::BC_SKIPC:
          fn = JUMP_COND[bctl] ? mseq_pkg::FN_SKIP : mseq_pkg::FN_NOP;
        default:
          fn = JUMP_COND[bctl] ? mseq_pkg::FN_JUMP : mseq_pkg::FN_NOP;
      endcase
    end
    else
    begin
      case (sequence_control_field)
        mseq_pkg::SC_NOP: fn = mseq_pkg::FN_NOP;
        mseq_pkg::SC_SKIP: fn = mseq_pkg::FN_SKIP;
        mseq_pkg::SC_RET: fn = mseq_pkg::FN_RET;
        mseq_pkg::SC_RET1: fn = mseq_pkg::FN_RET1;
        mseq_pkg::SC_POP: fn = mseq_pkg::FN_POP;
        mseq_pkg::SC_SKIPNF:
          fn = met ? mseq_pkg::FN_RET1 : mseq_pkg::FN_SKIP;
        mseq_pkg::SC_LOOPA, mseq_pkg::SC_LOOPB:
          fn = met ? mseq_pkg::FN_LOOP : mseq_pkg::FN_POP;
        mseq_pkg::SC_LOOPS:
          fn = met ? mseq_pkg::FN_LOOP :
            (SYNC_CASE ? mseq_pkg::FN_POPSKIP : mseq_pkg::FN_NOP);
        default: fn = met ? mseq_pkg::FN_SKIP : mseq_pkg::FN_NOP;
      endcase
    end
  end

  // Control levels per function
  always_comb
  begin
    case (fn)
      mseq_pkg::FN_NOP: {drive, rts, sp_en, cin, push, jmp} = 6'h20;
      mseq_pkg::FN_SKIP: {drive, rts, sp_en, cin, push, jmp} = 6'h24;
      mseq_pkg::FN_JUMP: {drive, rts, sp_en, cin, push, jmp} = 6'h21;
      mseq_pkg::FN_JSR: {drive, rts, sp_en, cin, push, jmp} = 6'h2b;
      mseq_pkg::FN_RET: {drive, rts, sp_en, cin, push, jmp} = 6'h18;
      mseq_pkg::FN_RET1: {drive, rts, sp_en, cin, push, jmp} = 6'h1c;
      mseq_pkg::FN_LOOP: {drive, rts, sp_en, cin, push, jmp} = 6'h10;
      mseq_pkg::FN_POP: {drive, rts, sp_en, cin, push, jmp} = 6'h28;
      mseq_pkg::FN_POPSKIP: {drive, rts, sp_en, cin, push, jmp} = 6'h2c;
      default: {drive, rts, sp_en, cin, push, jmp} = 6'h20;
    endcase
  end

  // -----------------------------------------------------------------
  // Next-address path
  // -----------------------------------------------------------------
  // Bus is the counter when driven, else the top entry on a return
  assign bus = drive ? upc_q : (rts ? stk.rd_data : 15'h0000);
  assign lo_en = jmp && (fmt == mseq_pkg::FMT_JUMP);
  assign rom_en = jmp && (fmt == mseq_pkg::FMT_DECODE);

  // Jump address: page flag on top, field below, low part by format
  always_comb
  begin
    jump_addr = {page_q,
      CURRENT_MICROWORD_REGISTER[mseq_pkg::WF_JHI +: 6], 8'h00};
    if (rom_en)
      jump_addr[7:0] = DISPATCH_DATA;
    else if (lo_en)
    begin
      jump_addr[7:5] = CURRENT_MICROWORD_REGISTER[mseq_pkg::WF_JMID +: 3];
      jump_addr[4:0] = CURRENT_MICROWORD_REGISTER[mseq_pkg::WF_JLO +: 5]
        | (CURRENT_MICROWORD_REGISTER[mseq_pkg::WF_SEL]
        ? SELECTOR_BITS : 5'h00);
    end
  end

  // Increment stays inside the 2K page by wrapping the low 11 bits
  assign nad_d = jmp ? jump_addr
    : {bus[14:11], 11'(bus[10:0] + {10'h000, cin})};

  // -----------------------------------------------------------------
  // Microcycle phases: T225 then T270
  // -----------------------------------------------------------------
  assign go = !maint && (run_q || step_q);

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
      ph_q <= mseq_pkg::PH_IDLE;
    else
    begin
      case (ph_q)
        mseq_pkg::PH_IDLE: ph_q <= go ? mseq_pkg::PH_T225 : mseq_pkg::PH_IDLE;
        mseq_pkg::PH_T225: ph_q <= mseq_pkg::PH_T270;
        mseq_pkg::PH_T270: ph_q <= mseq_pkg::PH_IDLE;
        default: ph_q <= mseq_pkg::PH_IDLE;
      endcase
    end
  end

  // Next address is captured at T225 so it is settled before the load
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
      nad_q <= mseq_pkg::UPC_RST;
    else if (ph_q == mseq_pkg::PH_T225)
      nad_q <= nad_d;
    else if (maint)
      nad_q <= upc_q;
  end

  // Counter: plus-one load at T270, or serial shift in maintenance
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
      upc_q <= mseq_pkg::UPC_RST;
    else if (shift_ev)
      upc_q <= {upc_q[13:0], sh_s[1]};
    else if (ph_q == mseq_pkg::PH_T270)
      upc_q <= 15'(nad_q + 15'h0001);
  end

  // Stack write at T225, one step below the pointer
  assign stk.wr_en = (ph_q == mseq_pkg::PH_T225) && push;
  assign stk.wr_addr = 4'(sp_q - 4'h1);
  assign stk.wr_data = bus;
  assign stk.rd_addr = sp_q;

  mseq_stack u_stack
  (
    .clk(CLOCK),
    .stk(stk)
  );

  // Pointer: wraps freely, down on push, up on pop
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
      sp_q <= mseq_pkg::SP_RST;
    else if (ph_q == mseq_pkg::PH_T270 && sp_en)
      sp_q <= push ? 4'(sp_q - 4'h1) : 4'(sp_q + 4'h1);
  end

  // Flags and page from the auxiliary word; class decode wins
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      flags_q <= 2'h0;
      page_q <= 1'b0;
    end
    else
    begin
      if (CLASS_DECODE_PHASE)
        flags_q <= 2'h0;
      else if (ph_q == mseq_pkg::PH_T270 && fmt == mseq_pkg::FMT_MISC)
        flags_q <= (flags_q | {misc[2], misc[0]})
          & ~{misc[3], misc[1]};
      if (ph_q == mseq_pkg::PH_T270 && fmt == mseq_pkg::FMT_MISC)
        page_q <= (page_q | misc[4]) & ~misc[5];
    end
  end

  // Registered copy of the T270 phase for the MICROCYCLE_END pin
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
      end_q <= 1'b0;
    else
      end_q <= (ph_q == mseq_pkg::PH_T270);
  end

  // -----------------------------------------------------------------
  // AXI4-Lite slave: one write and one read at a time
  // -----------------------------------------------------------------
  assign wr_fire = !awr_q && !wr_q && !bv_q;

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      awr_q <= 1'b1;
      wr_q <= 1'b1;
      bv_q <= 1'b0;
      br_q <= mseq_pkg::RESP_OKAY;
      aw_q <= 8'h00;
      wd_q <= 32'h00000000;
      ws_q <= 4'h0;
    end
    else
    begin
      if (S_AXI_AWVALID && awr_q)
      begin
        awr_q <= 1'b0;
        aw_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && wr_q)
      begin
        wr_q <= 1'b0;
        wd_q <= S_AXI_WDATA;
        ws_q <= S_AXI_WSTRB;
      end
      if (wr_fire)
      begin
        bv_q <= 1'b1;
        br_q <= (aw_q[7:2] == mseq_pkg::OFS_CTRL[7:2])
          ? mseq_pkg::RESP_OKAY : mseq_pkg::RESP_SLVERR;
      end
      if (bv_q && S_AXI_BREADY)
      begin
        bv_q <= 1'b0;
        awr_q <= 1'b1;
        wr_q <= 1'b1;
      end
    end
  end

  // Control register; a new step request beats its own consumption
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      run_q <= 1'b0;
      step_q <= 1'b0;
    end
    else if (wr_fire && aw_q[7:2] == mseq_pkg::OFS_CTRL[7:2] && ws_q[0])
    begin
      run_q <= wd_q[mseq_pkg::CTRL_RUN];
      step_q <= wd_q[mseq_pkg::CTRL_STEP] | step_q;
    end
    else if (ph_q == mseq_pkg::PH_IDLE && go)
      step_q <= 1'b0;
  end

  // Read side: status shows counter, pointer, flags and mode
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      arr_q <= 1'b1;
      rv_q <= 1'b0;
      rd_q <= 32'h00000000;
      rr_q <= mseq_pkg::RESP_OKAY;
    end
    else if (S_AXI_ARVALID && arr_q)
    begin
      arr_q <= 1'b0;
      rv_q <= 1'b1;
      rr_q <= mseq_pkg::RESP_OKAY;
      rd_q <= 32'h00000000;
      case (S_AXI_ARADDR[7:2])
        mseq_pkg::OFS_CTRL[7:2]: rd_q <= {30'h00000000, step_q, run_q};
        mseq_pkg::OFS_STAT[7:2]:
          rd_q <= {8'h00, maint, page_q, flags_q, sp_q, 1'b0, upc_q};
        mseq_pkg::OFS_NADR[7:2]: rd_q <= {17'h00000, nad_q};
        default: rr_q <= mseq_pkg::RESP_SLVERR;
      endcase
    end
    else if (rv_q && S_AXI_RREADY)
    begin
      rv_q <= 1'b0;
      arr_q <= 1'b1;
    end
  end

  assign S_AXI_AWREADY = awr_q;
  assign S_AXI_WREADY = wr_q;
  assign S_AXI_BVALID = bv_q;
  assign S_AXI_BRESP = br_q;
  assign S_AXI_ARREADY = arr_q;
  assign S_AXI_RVALID = rv_q;
  assign S_AXI_RDATA = rd_q;
  assign S_AXI_RRESP = rr_q;
  assign NEXT_ADDRESS_LINES = nad_q;
  assign COUNTER_MSB = upc_q[14];
  assign STATE_FLAGS = flags_q;
  assign USER_PAGE_FLAG = page_q;
  assign MICROCYCLE_END = end_q;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  property p_upc_load;
    ph_q == mseq_pkg::PH_T270 && !shift_ev
      |=> upc_q == 15'($past(nad_q) + 15'h0001);
  endproperty
  a_upc_load: assert property (p_upc_load) else $error("counter load");

  property p_shift;
    shift_ev |=> upc_q == {$past(upc_q[13:0]), $past(sh_s[1])};
  endproperty
  a_shift: assert property (p_shift) else $error("serial shift");

  property p_push;
    ph_q == mseq_pkg::PH_T270 && fn == mseq_pkg::FN_JSR
      |=> sp_q == 4'($past(sp_q) - 4'h1);
  endproperty
  a_push: assert property (p_push) else $error("push pointer");

  property p_pop;
    ph_q == mseq_pkg::PH_T270
      && (fn == mseq_pkg::FN_RET || fn == mseq_pkg::FN_POP)
      |=> sp_q == 4'($past(sp_q) + 4'h1);
  endproperty
  a_pop: assert property (p_pop) else $error("pop pointer");

  property p_loop;
    ph_q == mseq_pkg::PH_T270 && fn == mseq_pkg::FN_LOOP |=> $stable(sp_q);
  endproperty
  a_loop: assert property (p_loop) else $error("loop moved pointer");

  property p_skip;
    fn == mseq_pkg::FN_SKIP
      |-> nad_d == {upc_q[14:11], 11'(upc_q[10:0] + 11'h001)};
  endproperty
  a_skip: assert property (p_skip) else $error("skip address");

  property p_nop;
    fmt != mseq_pkg::FMT_JUMP && fmt != mseq_pkg::FMT_DECODE
      && sequence_control_field == mseq_pkg::SC_NOP |-> nad_d == upc_q;
  endproperty
  a_nop: assert property (p_nop) else $error("nop address");

  property p_ret;
    fn == mseq_pkg::FN_RET |-> nad_d == stk.rd_data;
  endproperty
  a_ret: assert property (p_ret) else $error("return address");

  property p_flag_clr;
    CLASS_DECODE_PHASE |=> flags_q == 2'h0;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flags");

  property p_cycle;
    ph_q == mseq_pkg::PH_T225 |=> ph_q == mseq_pkg::PH_T270 ##1 end_q;
  endproperty
  a_cycle: assert property (p_cycle) else $error("phases");

  c_jsr: cover property (ph_q == mseq_pkg::PH_T225 && fn == mseq_pkg::FN_JSR);
  c_ret: cover property (ph_q == mseq_pkg::PH_T270 && fn == mseq_pkg::FN_RET);
  c_shift: cover property (shift_ev);
endmodule // mseq_top
`default_nettype wire

//--- verification/mseq_console.sv
// Console model that shifts the micro-PC serially
`timescale 1ns/1ps
`default_nettype none
module mseq_console
(
  input wire logic clk,   // Sequencer clock
  output logic load_sel,  // Low selects shifting
  output logic shift_clk, // Shift step, still outside frames
  output logic shift_in   // Serial data into LSB
);
  // Idle levels: normal mode, clock at rest
  initial
  begin
    load_sel = 1'b1;
    shift_clk = 1'b0;
    shift_in = 1'b0;
  end
  // Pins pass a synchroniser, so each level is held six cycles
  task automatic shift(input logic [14:0] v);
    @(posedge clk);
    load_sel <= 1'b0;
    for (int i = 14; i >= 0; i--)
    begin
      shift_in <= v[i];
      repeat (6) @(posedge clk);
      shift_clk <= 1'b1;
      repeat (6) @(posedge clk);
      shift_clk <= 1'b0;
      repeat (6) @(posedge clk);
    end
    shift_in <= ~v[0]; // Released line no longer shows last bit
    load_sel <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule // mseq_console
`default_nettype wire

//--- verification/test_mseq_top.sv
// Self-checking bench for the micro-sequencer
`timescale 1ns/1ps
`default_nettype none
module test_mseq_top;
  logic clk = 0, rst_n = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic cdp = 0, awr, wr, bv, arr, rv, msb, pg, mce, ld, sck, sdi;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, skc = 0, rd, rdata;
  logic [23:0] mw = 24'h000015;
  logic [15:0] jc = 0;
  logic [14:0] upc, next_address_lines;
  logic [1:0] br, rr, rresp, flg;
  int num_errors = 0, checks_done = 0, cyc = 0;
  mseq_console con (.clk(clk), .load_sel(ld), .shift_clk(sck),
    .shift_in(sdi));
  mseq_top dut (.CLOCK(clk), .RESET_N(rst_n), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
    .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rre), .CURRENT_MICROWORD_REGISTER(mw),
    .SKIP_COND(skc), .JUMP_COND(jc), .SYNC_CASE(1'b0),
    .SELECTOR_BITS(5'h00), .DISPATCH_DATA(8'h00),
    .CLASS_DECODE_PHASE(cdp), .PARALLEL_LOAD_SELECT(ld),
    .COUNTER_CLOCK(sck), .CONSOLE_SHIFT_INPUT(sdi),
    .NEXT_ADDRESS_LINES(next_address_lines), .COUNTER_MSB(msb), .STATE_FLAGS(flg),
    .USER_PAGE_FLAG(pg), .MICROCYCLE_END(mce));
  // Clock and a hang guard sized well above the run length
  initial forever #4 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      num_errors++;
      complete_run;
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  // Each channel is released at the edge that takes it
  task axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
    forever
    begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wr) wv <= 0;
      if (bv) break;
    end
    bre <= 0;
    chk("bresp", package_okay(), br);
  endtask
  function automatic logic [1:0] package_okay();
    return mseq_pkg::RESP_OKAY;
  endfunction
  task axr(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    ara <= a; arv <= 1; rre <= 1;
    forever
    begin
      @(posedge clk);
      if (arr) arv <= 0;
      if (rv) break;
    end
    d = rdata; rr = rresp; rre <= 0;
  endtask
  // One single-stepped microcycle, then the next address is compared
  task step(input logic [23:0] w, input logic [14:0] e);
    mw <= w;
    axw(mseq_pkg::OFS_CTRL, 32'h00000002);
    forever
    begin
      @(posedge clk);
      if (mce) break;
    end
    chk("nad", e, next_address_lines);
    upc = e + 15'h0001;
  endtask
  task complete_run;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Main sequence; expected addresses follow from the decode tables
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    axr(mseq_pkg::OFS_STAT, rd);
    chk("status", 0, rd);
    con.shift(15'h0123);
    axr(mseq_pkg::OFS_STAT, rd);
    chk("upc", 15'h0123, rd[14:0]);
    step(24'h000015, 15'h0123);
    step(24'h00001e, 15'h0125);
    skc[5] <= 1;
    step(24'h000005, upc + 15'h0001);
    step(24'h000006, upc);
    step(24'h08240c, 15'h0240);
    axr(mseq_pkg::OFS_STAT, rd);
    chk("ptr", 4'hf, rd[19:16]);
    skc[17] <= 1;
    step(24'h000011, 15'h0129);
    step(24'h000016, 15'h012a);
    axr(mseq_pkg::OFS_STAT, rd);
    chk("ptr", 4'h0, rd[19:16]);
    step(24'h000012, upc);
    axr(mseq_pkg::OFS_STAT, rd);
    chk("ptr", 4'h1, rd[19:16]);
    step(24'h087fe4, 15'h07fe);
    step(24'h00001e, 15'h0000);
    step(24'h180035, upc);
    chk("flags", 2'h1, flg);
    cdp <= 1;
    repeat (3) @(posedge clk);
    chk("flags", 2'h0, flg);
    cdp <= 0;
    step(24'h180215, upc);
    chk("page", 1, pg);
    jc <= 16'h0008;
    step(24'h081002, upc);
    step(24'h081003, 15'h4100);
    chk("msb", 1, msb);
    axr(8'h0c, rd);
    chk("rresp", mseq_pkg::RESP_SLVERR, rr);
    complete_run;
  end
endmodule // test_mseq_top
`default_nettype wire
